//--- dv/pecr_regs_checker.sv
// checker: port-level properties of the capability register bank
module pecr_regs_checker
#(
	parameter logic [11:0] SER_NEXT_RESET = 12'h200,
	parameter logic [11:0] CHN_NEXT_RESET = 12'h000
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire pecr_pkg::pecr_err_hdr_t i_err,
	input wire logic i_err_clear,
	input wire logic [31:0] o_rdata,
	input wire logic o_err_held,
	input wire logic [63:0] o_serial,
	input wire logic [2:0] o_extra_channel_count,
	input wire logic [1:0] o_arbitration_entry_size
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic rd_ok = i_ce && i_rd;
	////////////////////////////////////////////////////////////////////////////////
	a_ser_id: assert property (rd_ok && i_addr == pecr_pkg::OFF_SER_CAP |=> o_rdata[15:0] == 16'h0003)
		else $error("serial header id wrong");
	a_ser_ver: assert property (rd_ok && i_addr == pecr_pkg::OFF_SER_CAP |=> o_rdata[19:16] == 4'h1)
		else $error("serial header version wrong");
	a_chn_id: assert property (rd_ok && i_addr == pecr_pkg::OFF_CHN_CAP |=> o_rdata[15:0] == 16'h0002)
		else $error("channel header id wrong");
	a_chn_ver: assert property (rd_ok && i_addr == pecr_pkg::OFF_CHN_CAP |=> o_rdata[19:16] == 4'h1)
		else $error("channel header version wrong");
	a_port_rsvd: assert property (rd_ok && i_addr == 12'h204 |=> {o_rdata[31:12], o_rdata[7], o_rdata[3]} == 22'h0)
		else $error("reserved bits of 0x204 not zero");
	a_tbase_zero: assert property (rd_ok && i_addr == 12'h204 |=> o_rdata[9:8] == 2'h0)
		else $error("time base field not zero");
	a_reset_vals: assert property ($rose(i_rst_n) |-> o_arbitration_entry_size == 2'h2 && o_extra_channel_count == 3'h0)
		else $error("channel fields wrong after reset");
	a_serial_reset: assert property ($rose(i_rst_n) |-> o_serial == 64'h0)
		else $error("serial number not zero after reset");
	// an error in the rearm cycle always lands, so the next read must show it
	a_log_first: assert property (i_ce && i_err.valid && i_err_clear ##1 rd_ok && i_addr == 12'h11C && !i_err.valid
		|=> o_rdata == $past(i_err.logged_header[0], 2))
		else $error("first header dword not logged");
endmodule
bind pecr_regs pecr_regs_checker #(.SER_NEXT_RESET(SER_NEXT_RESET), .CHN_NEXT_RESET(CHN_NEXT_RESET)) u_chk (.*);

//--- dv/pecr_regs_tb.sv
// testbench: register accesses and header logging of the capability register bank
module pecr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ce = 1'b1;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	pecr_pkg::pecr_err_hdr_t i_err = '0;
	logic i_err_clear = 1'b0;
	logic [31:0] o_rdata;
	logic o_err_held;
	logic [63:0] o_serial;
	logic [2:0] o_extra_channel_count;
	logic [1:0] o_arbitration_entry_size;
	int n_mismatch = 0;
	int check_count = 0;
	logic [3:0][31:0] ha = {32'hA3A3A3A3, 32'hA2A2A2A2, 32'hA1A1A1A1, 32'hA0A0A0A0};
	logic [3:0][31:0] hb = {32'hB3B3B3B3, 32'hB2B2B2B2, 32'hB1B1B1B1, 32'hB0B0B0B0};
	logic [11:0] offs [10] = '{12'h11C, 12'h120, 12'h124, 12'h128, 12'h180, 12'h184, 12'h188, 12'h200, 12'h204, 12'h300};
	logic [31:0] exps [10] = '{0, 0, 0, 0, 32'h20010003, 0, 0, 32'h00010002, 32'h00000800, 0};
	always #10 i_clk = ~i_clk;
	pecr_regs uut (.*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk($sformatf("read %h", a), exp, o_rdata);
	endtask
	task automatic err_rd(input logic [3:0][31:0] h, input logic c, input logic [3:0][31:0] e);
		@(posedge i_clk);
		i_err <= {1'b1, h};
		i_err_clear <= c;
		@(posedge i_clk);
		i_err <= {1'b0, h};
		i_err_clear <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= 12'h11C;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("log dword0", e[0], o_rdata);
		for (int k = 1; k < 4; k++)
			rd(12'h11C + 12'(4 * k), e[k]);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			rd(offs[i], exps[i]);
		chk("held idle", 0, {31'h0, o_err_held});
		$display("test reset values done");
		// locked until the unlock bit is set
		wr(12'h184, 32'hA5A55A5A);
		rd(12'h184, 0);
		wr(12'h3FC, 32'h00000001);
		rd(12'h3FC, 32'h00000001);
		wr(12'h184, 32'h01234567);
		wr(12'h188, 32'h89ABCDEF);
		rd(12'h184, 32'h01234567);
		rd(12'h188, 32'h89ABCDEF);
		chk("serial low", 32'h01234567, o_serial[31:0]);
		chk("serial high", 32'h89ABCDEF, o_serial[63:32]);
		$display("test serial done");
		wr(12'h204, 32'hFFFFFFFF);
		rd(12'h204, 32'h00000C77);
		chk("extra count", 32'h7, {29'h0, o_extra_channel_count});
		for (int e = 0; e < 4; e++)
		begin
			wr(12'h204, 32'(e) << 10);
			rd(12'h204, 32'(e) << 10);
			chk("entry size", 32'(e), {30'h0, o_arbitration_entry_size});
		end
		wr(12'h180, 32'hFFFFFFFF);
		rd(12'h180, 32'hFFF10003);
		wr(12'h180, 32'h00000000);
		rd(12'h180, 32'h00010003);
		wr(12'h200, 32'hFFFFFFFF);
		rd(12'h200, 32'hFFF10002);
		$display("test fields done");
		err_rd(ha, 1'b0, ha);
		repeat (2) @(posedge i_clk);
		chk("held", 1, {31'h0, o_err_held});
		err_rd(hb, 1'b0, ha);
		err_rd(hb, 1'b1, hb);
		// software may still overwrite a logged word while unlocked
		wr(12'h11C, 32'h5A5A5A5A);
		rd(12'h11C, 32'h5A5A5A5A);
		$display("test header log done");
		// a low clock enable must swallow the write strobe
		@(posedge i_clk);
		i_ce <= 1'b0;
		wr(12'h184, 32'hDEADBEEF);
		i_ce <= 1'b1;
		rd(12'h184, 32'h01234567);
		chk("serial frozen", 32'h01234567, o_serial[31:0]);
		$display("test clock enable done");
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 chk("serial after reset", 0, o_serial[31:0] | o_serial[63:32]);
		rd(12'h184, 0);
		rd(12'h204, 32'h00000800);
		rd(12'h11C, 0);
		$display("test second reset done");
		wrap_up();
	end
endmodule

//--- pkg/pecr_pkg.sv
// package: offsets, field layouts and reset values of the capability register bank
package pecr_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	localparam logic [11:0] OFF_HDR_LOG0 = 12'h11C;
	localparam logic [11:0] OFF_HDR_LOG1 = 12'h120;
	localparam logic [11:0] OFF_HDR_LOG2 = 12'h124;
	localparam logic [11:0] OFF_HDR_LOG3 = 12'h128;
	localparam logic [11:0] OFF_SER_CAP = 12'h180;
	localparam logic [11:0] OFF_SER_LOW = 12'h184;
	localparam logic [11:0] OFF_SER_HIGH = 12'h188;
	localparam logic [11:0] OFF_CHN_CAP = 12'h200;
	localparam logic [11:0] OFF_PORT_CHN1 = 12'h204;
	// control bit of our own: when set, software writes reach the locked fields
	localparam logic [11:0] OFF_UNLOCK = 12'h3FC;

	localparam logic [15:0] SER_CAP_ID = 16'h0003;
	localparam logic [15:0] CHN_CAP_ID = 16'h0002;
	localparam logic [3:0] CAP_VERSION = 4'h1;
	localparam int unsigned NEXT_LSB = 20;
	localparam int unsigned NEXT_W = 12;

	localparam int unsigned EXTRA_LSB = 0;
	localparam int unsigned LOWPRI_LSB = 4;
	localparam int unsigned TBASE_LSB = 8;
	localparam int unsigned ENTRY_LSB = 10;
	localparam logic [2:0] EXTRA_RESET = 3'h0;
	localparam logic [2:0] LOWPRI_RESET = 3'h0;
	localparam logic [1:0] TBASE_VALUE = 2'h0;
	localparam logic [1:0] ENTRY_RESET = 2'h2;
	localparam logic [31:0] WORD_RESET = 32'h00000000;

	typedef enum logic [1:0]
	{
		ENTRY_1BIT = 2'h0,
		ENTRY_2BIT = 2'h1,
		ENTRY_4BIT = 2'h2,
		ENTRY_8BIT = 2'h3
	} pecr_entry_size_t;

	typedef struct packed
	{
		logic [2:0] extra_channel_count;
		logic [2:0] low_priority_channel_count;
		pecr_entry_size_t arbitration_entry_size;
	} pecr_port_chn_t;

	typedef struct packed
	{
		logic valid;
		logic [3:0][31:0] logged_header;
	} pecr_err_hdr_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pecr_bus_req_t;

endpackage

//--- verilog/pecr_hdr_log.sv
// header log: four doublewords of the first uncorrectable error's packet header
module pecr_hdr_log
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire pecr_pkg::pecr_err_hdr_t i_err,
	input wire logic i_clear,
	input wire logic i_sw_wr,
	input wire logic [1:0] i_sw_idx,
	input wire logic [31:0] i_sw_data,
	output logic o_held,
	output logic [3:0][31:0] o_log
);

	typedef struct packed
	{
		logic held;
		logic [3:0][31:0] log;
	} pecr_hl_state_t;

	pecr_hl_state_t st;
	pecr_hl_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (i_sw_wr)
		begin
			next_st.log[i_sw_idx] = i_sw_data;
		end
		if (i_clear)
		begin
			next_st.held = 1'b0;
		end
		// only the first error is kept; a new one in the clear cycle still lands
		if (i_err.valid && (!st.held || i_clear))
		begin
			next_st.log = i_err.logged_header;
			next_st.held = 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			st <= '0;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign o_held = st.held;
	assign o_log = st.log;

endmodule

//--- verilog/pecr_regs.sv
// register bank: error header log, serial number and channel capability words
////////////////////////////////////////////////////////////////////////////////
//
// Operation
// - The first header doubleword of the first uncorrectable error packet is logged at 0x11C.
// - Header doublewords two to four of that packet are logged in order at 0x120, 0x124 and 0x128.
// - The serial capability header at 0x180 reads identifier 0x3 in bits 15:0.
// - The serial capability header reads version 0x1 in bits 19:16.
// - Bits 31:20 of each capability header hold the next capability offset, zero ending the list.
// - Offset 0x184 holds the low 32 bits of the 64-bit unique identifier, resetting to zero.
// - Offset 0x188 holds the high 32 bits of the 64-bit unique identifier, resetting to zero.
// - The channel capability header at 0x200 reads identifier 0x2 in bits 15:0.
// - The channel capability header reads version 0x1 in bits 19:16.
// - The extra channel count in bits 2:0 of 0x204 resets to zero, meaning only channel 0.
// - The low priority channel count in bits 6:4 resets to zero and means nothing.
// - The arbitration time base in bits 9:8 is read-only zero.
// - The arbitration entry size in bits 11:10 encodes 1, 2, 4, 8 bit entries and resets to 2.
module pecr_regs
#(
	parameter logic [11:0] SER_NEXT_RESET = 12'h200,
	parameter logic [11:0] CHN_NEXT_RESET = 12'h000
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire pecr_pkg::pecr_err_hdr_t i_err,
	input wire logic i_err_clear,
	output logic [31:0] o_rdata,
	output logic o_err_held,
	output logic [63:0] o_serial,
	output logic [2:0] o_extra_channel_count,
	output logic [1:0] o_arbitration_entry_size
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed
	{
		logic unlock;
		logic [11:0] ser_next;
		logic [11:0] chn_next;
		logic [31:0] ser_low;
		logic [31:0] ser_high;
		pecr_pkg::pecr_port_chn_t chn;
		logic [31:0] rdata;
		logic held;
		logic [63:0] serial;
		logic [2:0] extra;
		logic [1:0] entry;
	} pecr_state_t;

	pecr_state_t st;
	pecr_state_t next_st;
	logic log_held;
	logic [3:0][31:0] log_words;
	logic log_wr;
	logic [1:0] log_idx;

	function automatic logic [31:0] cap_header(input logic [15:0] id, input logic [11:0] nxt);
		cap_header = {nxt, pecr_pkg::CAP_VERSION, id};
	endfunction

	function automatic logic [31:0] port_chn_word(input pecr_pkg::pecr_port_chn_t c);
		port_chn_word = '0;
		port_chn_word[pecr_pkg::EXTRA_LSB +: 3] = c.extra_channel_count;
		port_chn_word[pecr_pkg::LOWPRI_LSB +: 3] = c.low_priority_channel_count;
		port_chn_word[pecr_pkg::TBASE_LSB +: 2] = pecr_pkg::TBASE_VALUE;
		port_chn_word[pecr_pkg::ENTRY_LSB +: 2] = c.arbitration_entry_size;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// locked log words accept software writes only while unlocked
	always_comb
	begin
		log_wr = 1'b0;
		log_idx = 2'h0;
		if (i_wr && st.unlock)
		begin
			unique case (i_addr)
				pecr_pkg::OFF_HDR_LOG0:
				begin
					log_wr = 1'b1;
					log_idx = 2'h0;
				end
				pecr_pkg::OFF_HDR_LOG1:
				begin
					log_wr = 1'b1;
					log_idx = 2'h1;
				end
				pecr_pkg::OFF_HDR_LOG2:
				begin
					log_wr = 1'b1;
					log_idx = 2'h2;
				end
				pecr_pkg::OFF_HDR_LOG3:
				begin
					log_wr = 1'b1;
					log_idx = 2'h3;
				end
				default:
				begin
					log_wr = 1'b0;
				end
			endcase
		end
	end

	pecr_hdr_log u_hdr_log
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_err(i_err),
		.i_clear(i_err_clear),
		.i_sw_wr(log_wr),
		.i_sw_idx(log_idx),
		.i_sw_data(i_wdata),
		.o_held(log_held),
		.o_log(log_words)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_st = st;
		if (i_wr)
		begin
			if (i_addr == pecr_pkg::OFF_UNLOCK)
			begin
				next_st.unlock = i_wdata[0];
			end
			else if (st.unlock)
			begin
				// identifier and version bits are constants, only the offset field takes writes
				unique case (i_addr)
					pecr_pkg::OFF_SER_CAP: next_st.ser_next = i_wdata[pecr_pkg::NEXT_LSB +: pecr_pkg::NEXT_W];
					pecr_pkg::OFF_CHN_CAP: next_st.chn_next = i_wdata[pecr_pkg::NEXT_LSB +: pecr_pkg::NEXT_W];
					pecr_pkg::OFF_SER_LOW: next_st.ser_low = i_wdata;
					pecr_pkg::OFF_SER_HIGH: next_st.ser_high = i_wdata;
					pecr_pkg::OFF_PORT_CHN1:
					begin
						// time base and reserved bits are dropped here
						next_st.chn.extra_channel_count = i_wdata[pecr_pkg::EXTRA_LSB +: 3];
						next_st.chn.low_priority_channel_count = i_wdata[pecr_pkg::LOWPRI_LSB +: 3];
						next_st.chn.arbitration_entry_size =
							pecr_pkg::pecr_entry_size_t'(i_wdata[pecr_pkg::ENTRY_LSB +: 2]);
					end
					default:
					begin
						next_st.unlock = st.unlock;
					end
				endcase
			end
		end

		// unmapped addresses and write-only cycles read back zero
		next_st.rdata = '0;
		if (i_rd)
		begin
			unique case (i_addr)
				pecr_pkg::OFF_HDR_LOG0: next_st.rdata = log_words[0];
				pecr_pkg::OFF_HDR_LOG1: next_st.rdata = log_words[1];
				pecr_pkg::OFF_HDR_LOG2: next_st.rdata = log_words[2];
				pecr_pkg::OFF_HDR_LOG3: next_st.rdata = log_words[3];
				pecr_pkg::OFF_SER_CAP: next_st.rdata = cap_header(pecr_pkg::SER_CAP_ID, st.ser_next);
				pecr_pkg::OFF_SER_LOW: next_st.rdata = st.ser_low;
				pecr_pkg::OFF_SER_HIGH: next_st.rdata = st.ser_high;
				pecr_pkg::OFF_CHN_CAP: next_st.rdata = cap_header(pecr_pkg::CHN_CAP_ID, st.chn_next);
				pecr_pkg::OFF_PORT_CHN1: next_st.rdata = port_chn_word(st.chn);
				pecr_pkg::OFF_UNLOCK: next_st.rdata = {31'h00000000, st.unlock};
				default: next_st.rdata = '0;
			endcase
		end

		// mirrors registered so every output leaves a flip-flop
		next_st.held = log_held;
		next_st.serial = {next_st.ser_high, next_st.ser_low};
		next_st.extra = next_st.chn.extra_channel_count;
		next_st.entry = next_st.chn.arbitration_entry_size;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			st.unlock <= 1'b0;
			st.ser_next <= SER_NEXT_RESET;
			st.chn_next <= CHN_NEXT_RESET;
			st.ser_low <= pecr_pkg::WORD_RESET;
			st.ser_high <= pecr_pkg::WORD_RESET;
			st.chn.extra_channel_count <= pecr_pkg::EXTRA_RESET;
			st.chn.low_priority_channel_count <= pecr_pkg::LOWPRI_RESET;
			st.chn.arbitration_entry_size <= pecr_pkg::ENTRY_4BIT;
			st.rdata <= pecr_pkg::WORD_RESET;
			st.held <= 1'b0;
			st.serial <= 64'h0000000000000000;
			st.extra <= pecr_pkg::EXTRA_RESET;
			st.entry <= pecr_pkg::ENTRY_RESET;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_err_held = st.held;
	assign o_serial = st.serial;
	assign o_extra_channel_count = st.extra;
	assign o_arbitration_entry_size = st.entry;

endmodule
